// ===== logic/lhlf_framer.sv
// host-link framer: command intake, text and binary record output
// Notes on behaviour
// - data goes out automatically or when host sends g
// - text values as sign, digit, point, five digits, E, sign, two digits
// - binary mode reports raw converter words of active channels only
// - each sample is a 16-bit word, result left-justified, low bits zero
// - multi-byte fields go out high byte first
// - live record: channel words ascending, four time bytes, then checksum
// - checksum is inverted XOR of all preceding record bytes
// - checksum only on serial link, omitted on USB
// - stored mode: each request returns one channel's points, then checksum
// - nothing follows the checksum, no terminator
// - serial link is 38400 baud, 8 bits, no parity, one stop
// - responses are text; sample data text or binary as selected
// - sleeping device loses first serial byte; lone s is ignored
// - serial link streams samples until collection stops or reset
// - USB delivers each requested sample once taken; late ones may be lost
// - USB IN transfers are whole multiples of 64 bytes
// - USB IN answered with NAK until data valid
// - USB live record padded with zero to 16 bytes, 1 to 4 per packet; code pads a 16-byte record to 32, so at most 2 fit
// - records per USB packet 1 to 4, default 1
// - live samples go out at once, not stored
// - input buffer holds up to 300 stacked command characters
`timescale 1ns/1ns
`default_nettype none
module lhlf_framer #(
    parameter int unsigned NCH = lhlf_pkg::MAX_CH,
    parameter int unsigned ADCW = lhlf_pkg::ADC_BITS,
    parameter int unsigned CMDD = lhlf_pkg::CMD_BUF_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_use_usb,
    input wire logic i_binary,
    input wire logic i_live_sampling_mode,
    input wire logic i_collecting,
    input wire logic i_asleep,
    input wire logic [2:0] i_pack_count,
    input wire logic [NCH-1:0] i_ch_active,
    input wire logic i_smp_valid,
    input wire logic [NCH*ADCW-1:0] i_smp_data,
    input wire logic [31:0] i_smp_time,
    output logic o_smp_ready,
    input wire logic i_blk_valid,
    input wire logic [ADCW-1:0] i_blk_data,
    input wire logic i_blk_last,
    output logic o_blk_ready,
    output logic o_blk_start,
    input wire logic i_txt_valid,
    input wire logic [31:0] i_txt_mant,
    input wire logic [6:0] i_txt_exp,
    input wire logic i_txt_last,
    output logic o_txt_ready,
    input wire logic i_cmd_rd,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_data,
    output logic o_get_req,
    input wire logic i_rxd,
    output logic o_txd,
    input wire logic i_usb_out_valid,
    input wire logic [7:0] i_usb_out_data,
    input wire logic i_usb_in_rd,
    output logic o_usb_in_nak,
    output logic o_usb_in_valid,
    output logic [7:0] o_usb_in_data,
    output logic o_usb_in_last
);
    lhlf_byte_if txb();
    logic rx_v;
    logic [7:0] rx_d;
    lhlf_uart u_uart (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .tx(txb),
        .i_rxd(i_rxd),
        .o_txd(o_txd),
        .o_rx_valid(rx_v),
        .o_rx_data(rx_d)
    );

    // decimal digit to ascii
    function automatic logic [7:0] asc(input logic [3:0] d);
        asc = lhlf_pkg::CHR_ZERO + {4'h0, d};
    endfunction

    // command intake: stacked, cr-delimited, up to CMDD chars
    logic [7:0] cbuf [CMDD];
    logic [8:0] wp_reg, wp_next, rp_reg, rp_next, cnt_reg, cnt_next;
    logic wake_reg, wake_next, inb_reg, inb_next, get_reg, get_next;
    logic in_v;
    logic [7:0] in_d;
    logic push;
    assign in_v = i_use_usb ? i_usb_out_valid : rx_v;
    assign in_d = i_use_usb ? i_usb_out_data : rx_d;
    assign o_cmd_valid = (cnt_reg != 9'h000);
    assign o_cmd_data = cbuf[rp_reg];
    assign o_get_req = get_reg;
    always_comb begin
        wake_next = wake_reg;
        inb_next = inb_reg;
        get_next = 1'b0;
        push = 1'b0;
        if (!i_asleep) begin
            wake_next = 1'b0;
        end
        if (in_v) begin
            if (i_asleep && !i_use_usb && !wake_reg) begin
                wake_next = 1'b1;
            end else if (in_d == lhlf_pkg::CHR_GET && !inb_reg) begin
                get_next = 1'b1;
            end else if (in_d == lhlf_pkg::CHR_LBRACE) begin
                inb_next = 1'b1;
                push = 1'b1;
            end else if (inb_reg) begin
                push = 1'b1;
                if (in_d == lhlf_pkg::CHR_RBRACE) begin
                    inb_next = 1'b0;
                end
            end else if (in_d == lhlf_pkg::CHR_CR) begin
                push = 1'b1;
            end
            // a lone s outside braces is dropped
        end
        if (cnt_reg == 9'(CMDD)) begin
            push = 1'b0;
        end
        wp_next = push ? ((wp_reg == 9'(CMDD - 1)) ? 9'h000
            : wp_reg + 9'h001) : wp_reg;
        rp_next = (i_cmd_rd && o_cmd_valid) ? ((rp_reg == 9'(CMDD - 1))
            ? 9'h000 : rp_reg + 9'h001) : rp_reg;
        cnt_next = cnt_reg + {8'h00, push}
            - {8'h00, i_cmd_rd && o_cmd_valid};
    end
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            cbuf[wp_reg] <= in_d;
        end
    end

    // output byte generator
    lhlf_pkg::lhlf_src_e src_reg, src_next;
    logic [NCH*ADCW-1:0] wsh_reg, wsh_next;
    logic [NCH-1:0] act_reg, act_next;
    logic [31:0] tm_reg, tm_next;
    logic [7:0] chk_reg, chk_next;
    logic [3:0] idx_reg, idx_next;
    logic hi_reg, hi_next, blk_reg, blk_next;
    logic [6:0] pk_reg, pk_next;
    logic [2:0] nrec_reg, nrec_next;
    logic [7:0] tb [13];
    logic [7:0] ob;
    logic ov, stall, take;
    logic [15:0] word;
    logic [2:0] pack;

    assign pack = (i_pack_count == 3'h0
        || i_pack_count > 3'(lhlf_pkg::PACK_MAX))
        ? 3'h1 : i_pack_count;
    // raw result left-justified, low bits zero
    assign word = blk_reg ? {i_blk_data, (16 - ADCW)'(0)}
        : {wsh_reg[ADCW-1:0], (16 - ADCW)'(0)};
    // sm.dddddEsee
    always_comb begin
        tb[0] = i_txt_mant[31] ? lhlf_pkg::CHR_MINUS : lhlf_pkg::CHR_PLUS;
        tb[1] = asc(i_txt_mant[23:20]);
        tb[2] = lhlf_pkg::CHR_DOT;
        tb[3] = asc(i_txt_mant[19:16]);
        tb[4] = asc(i_txt_mant[15:12]);
        tb[5] = asc(i_txt_mant[11:8]);
        tb[6] = asc(i_txt_mant[7:4]);
        tb[7] = asc(i_txt_mant[3:0]);
        tb[8] = lhlf_pkg::CHR_E;
        tb[9] = i_txt_exp[6] ? lhlf_pkg::CHR_MINUS : lhlf_pkg::CHR_PLUS;
        tb[10] = asc({1'b0, i_txt_exp[5:3]});
        tb[11] = asc({1'b0, i_txt_exp[2:0]});
        tb[12] = lhlf_pkg::CHR_CR;
    end
    always_comb begin
        ob = 8'h00;
        ov = 1'b0;
        unique case (src_reg)
            lhlf_pkg::LHLF_SRC_IDLE: begin
                ov = 1'b0;
            end
            lhlf_pkg::LHLF_SRC_TEXT: begin
                ov = i_txt_valid;
                ob = tb[idx_reg];
            end
            lhlf_pkg::LHLF_SRC_WORDS: begin
                // nothing offered while an inactive channel is skipped
                ov = blk_reg ? i_blk_valid : act_reg[0];
                ob = hi_reg ? word[15:8] : word[7:0];
            end
            lhlf_pkg::LHLF_SRC_TIME: begin
                ov = 1'b1;
                ob = tm_reg[31:24];
            end
            lhlf_pkg::LHLF_SRC_CHK: begin
                ov = 1'b1;
                ob = ~chk_reg;
            end
            lhlf_pkg::LHLF_SRC_PAD: begin
                ov = 1'b1;
                ob = 8'h00;
            end
        endcase
    end
    assign stall = i_use_usb ? !i_usb_in_rd : !txb.ready;
    assign take = ov && !stall;
    assign txb.valid = ov && !i_use_usb;
    assign txb.data = ob;
    assign o_usb_in_valid = ov && i_use_usb;
    assign o_usb_in_data = ob;
    assign o_usb_in_nak = i_use_usb && !ov;
    assign o_usb_in_last = i_use_usb && ov
        && pk_reg == 7'(lhlf_pkg::USB_PKT_BYTES - 1);
    assign o_smp_ready = (src_reg == lhlf_pkg::LHLF_SRC_IDLE) && i_binary
        && i_live_sampling_mode && i_collecting;
    assign o_blk_ready = blk_reg && src_reg == lhlf_pkg::LHLF_SRC_WORDS
        && !hi_reg && take;
    assign o_txt_ready = src_reg == lhlf_pkg::LHLF_SRC_TEXT && take
        && (idx_reg == 4'hC || (idx_reg == 4'hB && !i_txt_last));
    assign o_blk_start = (src_reg == lhlf_pkg::LHLF_SRC_IDLE) && i_binary
        && !i_live_sampling_mode && get_reg;

    always_comb begin
        src_next = src_reg;
        wsh_next = wsh_reg;
        act_next = act_reg;
        tm_next = tm_reg;
        chk_next = chk_reg;
        idx_next = idx_reg;
        hi_next = hi_reg;
        blk_next = blk_reg;
        pk_next = pk_reg;
        nrec_next = nrec_reg;
        if (take) begin
            chk_next = chk_reg ^ ob;
            pk_next = pk_reg + 7'h01;
            if (pk_reg == 7'(lhlf_pkg::USB_PKT_BYTES - 1)) begin
                pk_next = 7'h00;
            end
        end
        unique case (src_reg)
            lhlf_pkg::LHLF_SRC_IDLE: begin
                chk_next = 8'h00;
                idx_next = 4'h0;
                hi_next = 1'b1;
                if (o_smp_ready && i_smp_valid) begin
                    // capture one live record
                    wsh_next = i_smp_data;
                    act_next = i_ch_active;
                    tm_next = i_smp_time;
                    blk_next = 1'b0;
                    src_next = lhlf_pkg::LHLF_SRC_WORDS;
                end else if (o_blk_start) begin
                    blk_next = 1'b1;
                    src_next = lhlf_pkg::LHLF_SRC_WORDS;
                end else if (i_txt_valid) begin
                    src_next = lhlf_pkg::LHLF_SRC_TEXT;
                end
            end
            lhlf_pkg::LHLF_SRC_TEXT: begin
                if (take) begin
                    idx_next = idx_reg + 4'h1;
                    if (idx_reg == 4'hB && !i_txt_last) begin
                        idx_next = 4'h0;
                    end else if (idx_reg == 4'hC) begin
                        idx_next = 4'h0;
                        src_next = i_use_usb && pk_next != 7'h00
                            ? lhlf_pkg::LHLF_SRC_PAD
                            : lhlf_pkg::LHLF_SRC_IDLE;
                    end
                end
            end
            lhlf_pkg::LHLF_SRC_WORDS: begin
                if (!blk_reg && !act_reg[0]) begin
                    // skip inactive channel, ascending order
                    wsh_next = wsh_reg >> ADCW;
                    act_next = act_reg >> 1;
                    if (act_reg[NCH-1:1] == '0) begin
                        src_next = lhlf_pkg::LHLF_SRC_TIME;
                    end
                end else if (take) begin
                    hi_next = !hi_reg;
                    if (!hi_reg) begin
                        if (blk_reg) begin
                            if (i_blk_last) begin
                                src_next = i_use_usb ? lhlf_pkg::LHLF_SRC_PAD
                                    : lhlf_pkg::LHLF_SRC_CHK;
                            end
                        end else begin
                            wsh_next = wsh_reg >> ADCW;
                            act_next = {1'b0, act_reg[NCH-1:1]};
                            if (act_reg[NCH-1:1] == '0) begin
                                src_next = lhlf_pkg::LHLF_SRC_TIME;
                            end
                        end
                    end
                end
            end
            lhlf_pkg::LHLF_SRC_TIME: begin
                if (take) begin
                    tm_next = {tm_reg[23:0], 8'h00};
                    idx_next = idx_reg + 4'h1;
                    if (idx_reg == 4'h3) begin
                        idx_next = 4'h0;
                        src_next = i_use_usb ? lhlf_pkg::LHLF_SRC_PAD
                            : lhlf_pkg::LHLF_SRC_CHK;
                    end
                end
            end
            lhlf_pkg::LHLF_SRC_CHK: begin
                if (take) begin
                    src_next = lhlf_pkg::LHLF_SRC_IDLE;
                end
            end
            lhlf_pkg::LHLF_SRC_PAD: begin
                if (take) begin
                    // live record: at least one zero, then pad to a 16-byte boundary, pack records
                    if (!blk_reg && pk_next[3:0] == 4'h0
                        && nrec_reg + 3'h1 < pack) begin
                        nrec_next = nrec_reg + 3'h1;
                        src_next = lhlf_pkg::LHLF_SRC_IDLE;
                    end else if (pk_next == 7'h00) begin
                        nrec_next = 3'h0;
                        src_next = lhlf_pkg::LHLF_SRC_IDLE;
                    end
                end
            end
            default: src_next = lhlf_pkg::LHLF_SRC_IDLE;
        endcase
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wp_reg <= 9'h000;
            rp_reg <= 9'h000;
            cnt_reg <= 9'h000;
            wake_reg <= 1'b0;
            inb_reg <= 1'b0;
            get_reg <= 1'b0;
            src_reg <= lhlf_pkg::LHLF_SRC_IDLE;
            wsh_reg <= '0;
            act_reg <= '0;
            tm_reg <= 32'h0000_0000;
            chk_reg <= 8'h00;
            idx_reg <= 4'h0;
            hi_reg <= 1'b1;
            blk_reg <= 1'b0;
            pk_reg <= 7'h00;
            nrec_reg <= 3'h0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            wake_reg <= wake_next;
            inb_reg <= inb_next;
            get_reg <= get_next;
            src_reg <= src_next;
            wsh_reg <= wsh_next;
            act_reg <= act_next;
            tm_reg <= tm_next;
            chk_reg <= chk_next;
            idx_reg <= idx_next;
            hi_reg <= hi_next;
            blk_reg <= blk_next;
            pk_reg <= pk_next;
            nrec_reg <= nrec_next;
        end
    end
endmodule
`default_nettype wire

// ===== logic/lhlf_pkg.sv
// constants and types shared by the host-link framer
package lhlf_pkg;
    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned BAUD = 38400;
    localparam int unsigned BAUD_DIV = CLK_HZ / BAUD;
    localparam int unsigned CMD_BUF_DEPTH = 300;
    localparam int unsigned USB_PKT_BYTES = 64;
    localparam int unsigned USB_REC_BYTES = 16;
    localparam int unsigned PACK_MAX = 4;
    localparam int unsigned ADC_BITS = 12;
    localparam int unsigned MAX_CH = 6;
    localparam logic [7:0] CHR_CR = 8'h0D;
    localparam logic [7:0] CHR_GET = 8'h67;
    localparam logic [7:0] CHR_S = 8'h73;
    localparam logic [7:0] CHR_LBRACE = 8'h7B;
    localparam logic [7:0] CHR_RBRACE = 8'h7D;
    localparam logic [7:0] CHR_PLUS = 8'h2B;
    localparam logic [7:0] CHR_MINUS = 8'h2D;
    localparam logic [7:0] CHR_DOT = 8'h2E;
    localparam logic [7:0] CHR_E = 8'h45;
    localparam logic [7:0] CHR_ZERO = 8'h30;
    typedef enum logic [2:0] {
        LHLF_SRC_IDLE = 3'b000,
        LHLF_SRC_TEXT = 3'b001,
        LHLF_SRC_WORDS = 3'b010,
        LHLF_SRC_TIME = 3'b011,
        LHLF_SRC_CHK = 3'b100,
        LHLF_SRC_PAD = 3'b101
    } lhlf_src_e;
endpackage

// ===== logic/lhlf_byte_if.sv
// byte stream between the framer core and its serial transmitter
`timescale 1ns/1ns
`default_nettype none
interface lhlf_byte_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== logic/lhlf_uart.sv
// 8N1 serial transmitter and receiver with two-flop input sync
`timescale 1ns/1ns
`default_nettype none
module lhlf_uart #(
    parameter int unsigned DIV = lhlf_pkg::BAUD_DIV
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    lhlf_byte_if.snk tx,
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data
);
    logic [15:0] tcnt_reg, tcnt_next;
    logic [3:0] tbit_reg, tbit_next;
    logic [9:0] tsh_reg, tsh_next;
    logic [15:0] rcnt_reg, rcnt_next;
    logic [3:0] rbit_reg, rbit_next;
    logic [7:0] rsh_reg, rsh_next;
    logic rv_reg, rv_next;
    logic [7:0] rd_reg, rd_next;
    logic s1_reg, s2_reg;
    assign tx.ready = (tbit_reg == 4'h0);
    assign o_txd = tsh_reg[0];
    assign o_rx_valid = rv_reg;
    assign o_rx_data = rd_reg;
    always_comb begin
        tcnt_next = tcnt_reg;
        tbit_next = tbit_reg;
        tsh_next = tsh_reg;
        if (tbit_reg == 4'h0) begin
            if (tx.valid) begin
                // stop, 8 data lsb first, start: 38400 8N1
                tsh_next = {1'b1, tx.data, 1'b0};
                tbit_next = 4'hA;
                tcnt_next = 16'(DIV - 1);
            end
        end else if (tcnt_reg == 16'h0000) begin
            tsh_next = {1'b1, tsh_reg[9:1]};
            tbit_next = tbit_reg - 4'h1;
            tcnt_next = 16'(DIV - 1);
        end else begin
            tcnt_next = tcnt_reg - 16'h0001;
        end
    end
    always_comb begin
        rcnt_next = rcnt_reg;
        rbit_next = rbit_reg;
        rsh_next = rsh_reg;
        rv_next = 1'b0;
        rd_next = rd_reg;
        if (rbit_reg == 4'h0) begin
            if (!s2_reg) begin
                rbit_next = 4'h9;
                rcnt_next = 16'(DIV + DIV / 2 - 1);
            end
        end else if (rcnt_reg == 16'h0000) begin
            rcnt_next = 16'(DIV - 1);
            rbit_next = rbit_reg - 4'h1;
            if (rbit_reg == 4'h1) begin
                rv_next = s2_reg;
                rd_next = rsh_reg;
            end else begin
                rsh_next = {s2_reg, rsh_reg[7:1]};
            end
        end else begin
            rcnt_next = rcnt_reg - 16'h0001;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            tcnt_reg <= 16'h0000;
            tbit_reg <= 4'h0;
            tsh_reg <= 10'h3FF;
            rcnt_reg <= 16'h0000;
            rbit_reg <= 4'h0;
            rsh_reg <= 8'h00;
            rv_reg <= 1'b0;
            rd_reg <= 8'h00;
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
        end else begin
            tcnt_reg <= tcnt_next;
            tbit_reg <= tbit_next;
            tsh_reg <= tsh_next;
            rcnt_reg <= rcnt_next;
            rbit_reg <= rbit_next;
            rsh_reg <= rsh_next;
            rv_reg <= rv_next;
            rd_reg <= rd_next;
            s1_reg <= i_rxd;
            s2_reg <= s1_reg;
        end
    end
endmodule
`default_nettype wire

// ===== bench/lhlf_framer_chk.sv
// port-level assertions for the host-link framer
`timescale 1ns/1ns
`default_nettype none
module lhlf_framer_chk (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_use_usb,
    input wire logic i_usb_in_rd,
    input wire logic i_cmd_rd,
    input wire logic o_txd,
    input wire logic o_usb_in_nak,
    input wire logic o_usb_in_valid,
    input wire logic [7:0] o_usb_in_data,
    input wire logic o_usb_in_last,
    input wire logic o_cmd_valid,
    input wire logic [7:0] o_cmd_data,
    input wire logic o_get_req,
    input wire logic o_blk_start
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    always_comb begin
        cnt_next = cnt_reg;
        if (o_usb_in_valid && i_usb_in_rd) begin
            cnt_next = cnt_reg + 6'h01;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            cnt_reg <= 6'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    idle_after_reset_a: assert property ($fell(i_rst) |->
        o_txd && (o_usb_in_nak == i_use_usb))
        else $error("outputs not idle after reset");
    nak_excludes_data_a: assert property (o_usb_in_valid |->
        !o_usb_in_nak) else $error("nak raised with data");
    usb_byte_stands_a: assert property (o_usb_in_valid && !i_usb_in_rd |=>
        o_usb_in_valid && $stable(o_usb_in_data))
        else $error("usb byte dropped before taken");
    last_with_data_a: assert property (o_usb_in_last |-> o_usb_in_valid)
        else $error("last without valid byte");
    packet_length_a: assert property (o_usb_in_valid && i_usb_in_rd |->
        (o_usb_in_last == (cnt_reg == 6'h3F)))
        else $error("usb packet not 64 bytes");
    start_bit_a: assert property ($fell(o_txd) |=> !o_txd [*8])
        else $error("start bit too short");
    get_pulse_a: assert property (o_get_req |=> !o_get_req)
        else $error("get request longer than one cycle");
    block_pulse_a: assert property (o_blk_start |=> !o_blk_start)
        else $error("block start longer than one cycle");
    cmd_byte_stands_a: assert property (o_cmd_valid && !i_cmd_rd |=>
        o_cmd_valid && $stable(o_cmd_data))
        else $error("command byte lost");
    cover property (o_usb_in_last && i_usb_in_rd);
    cover property (o_blk_start);
    cover property ($fell(o_txd));
endmodule
bind lhlf_framer lhlf_framer_chk chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_use_usb(i_use_usb), .i_usb_in_rd(i_usb_in_rd), .i_cmd_rd(i_cmd_rd),
    .o_txd(o_txd), .o_usb_in_nak(o_usb_in_nak),
    .o_usb_in_valid(o_usb_in_valid), .o_usb_in_data(o_usb_in_data),
    .o_usb_in_last(o_usb_in_last), .o_cmd_valid(o_cmd_valid),
    .o_cmd_data(o_cmd_data), .o_get_req(o_get_req),
    .o_blk_start(o_blk_start));
`default_nettype wire

// ===== bench/lhlf_host_model.sv
// serial host: idles its line high, decodes bytes from the device
`timescale 1ns/1ns
`default_nettype none
module lhlf_host_model #(
    parameter int unsigned DIV = lhlf_pkg::BAUD_DIV
) (
    input wire logic i_sys_clk,
    input wire logic i_txd,
    output logic o_rxd,
    output logic o_got,
    output logic [7:0] o_got_data
);
    initial begin
        o_rxd = 1'b1;
        o_got = 1'b0;
        o_got_data = 8'h00;
        forever begin
            @(negedge i_txd);
            repeat (DIV / 2) @(posedge i_sys_clk);
            for (int i = 0; i < 9; i++) begin
                repeat (DIV) @(posedge i_sys_clk);
                if (i < 8) begin
                    o_got_data[i] <= i_txd;
                end
            end
            o_got <= i_txd;
            @(posedge i_sys_clk);
            o_got <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== bench/test_logger_host_link_framer.sv
// self-checking bench for the host-link framer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin \
    samples_checked++; \
    if ((a) !== (e)) begin \
        errors++; \
        $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); \
    end \
end
module test_logger_host_link_framer;
    logic clk, sr, br, bs, cv, gr, rxd, txd, nak, iv, il, got;
    logic rst = 1'b1, usb = 1'b1, live = 1'b1, sv = 1'b0, bv = 1'b0;
    logic bl = 1'b0, crd = 1'b0, ov = 1'b0, ird = 1'b0, slp = 1'b0;
    logic bin = 1'b1, col = 1'b1;
    logic [2:0] pack = 3'h1;
    logic [1:0] act = 2'h1;
    logic [23:0] sd = 24'h0;
    logic [31:0] st = 32'h0;
    logic [11:0] bd = 12'h0;
    logic [7:0] od = 8'h0;
    logic [7:0] cd, idat, gdat;
    logic [7:0] exq[$];
    int errors = 0, samples_checked = 0, cyc = 0;
    logic [1:0] rm[3] = '{2'h1, 2'h2, 2'h3};
    logic [23:0] rdat[3] = '{24'h00008C, 24'hFFF000, 24'hA5C3F1};
    logic [31:0] rtim[3] = '{32'h000000E0, 32'h12345678, 32'hFFFFFFFF};
    lhlf_framer #(.NCH(2)) uut (.i_sys_clk(clk), .i_rst(rst),
        .i_use_usb(usb), .i_binary(bin), .i_live_sampling_mode(live),
        .i_collecting(col), .i_asleep(slp), .i_pack_count(pack),
        .i_ch_active(act), .i_smp_valid(sv), .i_smp_data(sd),
        .i_smp_time(st), .o_smp_ready(sr), .i_blk_valid(bv),
        .i_blk_data(bd), .i_blk_last(bl), .o_blk_ready(br),
        .o_blk_start(bs), .i_txt_valid(1'b0), .i_txt_mant(32'h0),
        .i_txt_exp(7'h0), .i_txt_last(1'b0), .o_txt_ready(),
        .i_cmd_rd(crd), .o_cmd_valid(cv), .o_cmd_data(cd),
        .o_get_req(gr), .i_rxd(rxd), .o_txd(txd), .i_usb_out_valid(ov),
        .i_usb_out_data(od), .i_usb_in_rd(ird), .o_usb_in_nak(nak),
        .o_usb_in_valid(iv), .o_usb_in_data(idat), .o_usb_in_last(il));
    lhlf_host_model host (.i_sys_clk(clk), .i_txd(txd), .o_rxd(rxd),
        .o_got(got), .o_got_data(gdat));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic push_rec(input logic [1:0] m, input logic [23:0] d,
        input logic [31:0] t);
        logic [15:0] w;
        for (int c = 0; c < 2; c++) begin
            w = {d[c*12+:12], 4'h0};
            if (m[c]) exq.push_back(w[15:8]);
            if (m[c]) exq.push_back(w[7:0]);
        end
        for (int b = 3; b >= 0; b--) exq.push_back(t[b*8+:8]);
        while (exq.size() % 16 != 0) exq.push_back(8'h00);
    endtask
    task automatic put_smp(input logic [1:0] m, input logic [23:0] d,
        input logic [31:0] t);
        act <= m;
        sd <= d;
        st <= t;
        sv <= 1'b1;
        do @(posedge clk); while (sr !== 1'b1);
        sv <= 1'b0;
        @(posedge clk);
    endtask
    task automatic read_pkt;
        ird <= 1'b1;
        for (int i = 0; i < 64; i++) begin
            do @(posedge clk); while (iv !== 1'b1);
            `CHK(idat, i < exq.size() ? exq[i] : 8'h00)
            `CHK(il, i == 63)
        end
        ird <= 1'b0;
        @(posedge clk);
        exq.delete();
    endtask
    task automatic send_out(input string s);
        foreach (s[i]) begin
            ov <= 1'b1;
            od <= s[i];
            @(posedge clk);
        end
        ov <= 1'b0;
    endtask
    initial begin
        string cs = "{7}\r";
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(txd, 1'b1)
        `CHK(nak, 1'b1)
        for (int r = 0; r < 3; r++) begin
            push_rec(rm[r], rdat[r], rtim[r]);
            fork
                put_smp(rm[r], rdat[r], rtim[r]);
                read_pkt();
            join
        end
        pack <= 3'h2;
        push_rec(2'h3, 24'h123456, 32'hCAFE0001);
        push_rec(2'h1, 24'h000FFF, 32'h00000002);
        fork
            begin
                put_smp(2'h3, 24'h123456, 32'hCAFE0001);
                put_smp(2'h1, 24'h000FFF, 32'h00000002);
            end
            read_pkt();
        join
        slp <= 1'b1;
        send_out("s{7}\r");
        slp <= 1'b0;
        crd <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            do @(posedge clk); while (cv !== 1'b1);
            `CHK(cd, cs[i])
        end
        crd <= 1'b0;
        live <= 1'b0;
        send_out("g");
        do @(posedge clk); while (bs !== 1'b1);
        `CHK(gr, 1'b1)
        exq = '{8'hAB, 8'hC0, 8'h00, 8'h10};
        fork
            begin
                bv <= 1'b1;
                bd <= 12'hABC;
                do @(posedge clk); while (br !== 1'b1);
                bd <= 12'h001;
                bl <= 1'b1;
                do @(posedge clk); while (br !== 1'b1);
                bv <= 1'b0;
            end
            read_pkt();
        join
        usb <= 1'b0;
        live <= 1'b1;
        col <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK(txd, 1'b1)
        `CHK(nak, 1'b0)
        `CHK(sr, 1'b0)
        col <= 1'b1;
        put_smp(2'h1, 24'h00008C, 32'h000000E0);
        for (int k = 0; k < 2; k++) begin
            do @(posedge clk); while (got !== 1'b1);
            `CHK(gdat, k == 0 ? 8'h08 : 8'hC0)
        end
        complete_run();
    end
endmodule
`default_nettype wire
